//--- pkg/eivs_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef EIVS_REGS_SVH
`define EIVS_REGS_SVH
`define EIVS_MCU_CONTROL_ADDR 8'h35
`define EIVS_MCU_CONTROL_RST  8'h00
`define EIVS_BIT_CHANGE_EN    0
`define EIVS_BIT_TABLE_SEL    1
`define EIVS_BIT_PULLUP_DIS   4
`define EIVS_BIT_DEBUG_DIS    7
`define EIVS_MCU_WR_MASK      8'h93
`define EIVS_CHANGE_WINDOW    3'h4
`define EIVS_SENSE_LOW        2'h0
`define EIVS_SENSE_ANY        2'h1
`define EIVS_SENSE_FALL       2'h2
`define EIVS_SENSE_RISE       2'h3
`define EIVS_PIN_COUNT        31
`define EIVS_GROUP_COUNT      4
`endif

//--- pkg/eivs_pkg.sv
// Types shared by the vector select and external interrupt front-end.
package eivs_pkg;
   // Phase of the protected vector table change sequence.
   typedef enum logic [1:0] {
      EIVS_IDLE,
      EIVS_ARMED,
      EIVS_TRAIL
   } eivs_seq_t;
endpackage

//--- core/eivs_core.sv
// Vector table select sequence and external and pin-change detection.
`timescale 1ns/1ps
`include "eivs_regs.svh"

module eivs_core #(
   parameter int PINS   = `EIVS_PIN_COUNT,
   parameter int GROUPS = `EIVS_GROUP_COUNT
) (
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic [7:0]        io_addr,
   input  wire logic              io_wr,
   input  wire logic [7:0]        io_wdata,
   output logic      [7:0]        io_rdata,
   input  wire logic              global_irq_enable,
   input  wire logic              ext_irq_enable,
   input  wire logic [GROUPS-1:0] pin_change_enable,
   input  wire logic [2:0]        ext_irq_control_reg,
   input  wire logic [7:0]        pin_change_mask_grp0,
   input  wire logic [7:0]        pin_change_mask_grp1,
   input  wire logic [7:0]        pin_change_mask_grp2,
   input  wire logic [7:0]        pin_change_mask_grp3,
   input  wire logic              flag_clear_ext,
   input  wire logic [GROUPS-1:0] flag_clear_grp,
   input  wire logic              handler_entry_ext,
   input  wire logic [GROUPS-1:0] handler_entry_grp,
   input  wire logic              ext_irq_pin,
   input  wire logic [PINS-1:0]   pin_change_inputs,
   input  wire logic              io_clock_running,
   input  wire logic              startup_done,
   input  wire logic              exec_in_boot,
   input  wire logic              app_side_boot_lock,
   input  wire logic              boot_side_boot_lock,
   output logic                   vector_table_select,
   output logic                   irq_blocked,
   output logic                   ext_irq_flag,
   output logic [GROUPS-1:0]      pin_change_flag,
   output logic                   ext_irq_take,
   output logic [GROUPS-1:0]      pin_change_take,
   output logic                   wake_request
);

   // Control register bits that software writes, then sequence, sync and request state.
   logic                   change_enable;     // Armed enable bit.
   logic                   pullup_disable;    // Stored, used elsewhere.
   logic                   debug_port_disable;// Stored, used elsewhere.
   logic [2:0]             window_cnt;        // Cycles since arming.
   eivs_pkg::eivs_seq_t    seq_state;         // Sequence phase.
   logic                   mcu_wr;            // Write to control reg.
   logic [1:0]             sense_mode;        // Sense control field.
   logic                   sense_control_hi;  // Upper sense bit.
   logic                   sense_control_lo;  // Lower sense bit.
   logic                   ext_sync1;         // First sync stage only.
   logic                   ext_sync2;         // Second sync stage.
   logic                   ext_prev;          // Previous sample.
   logic [PINS-1:0]        pc_sync1;          // First sync stage only.
   logic [PINS-1:0]        pc_sync2;          // Second sync stage.
   logic [PINS-1:0]        pc_prev;           // Previous samples.
   logic [8*GROUPS-1:0]    pc_mask;           // Joined mask bytes.
   logic [GROUPS-1:0]      grp_event;         // Group toggle events.
   logic                   ext_event;         // Edge event on the pin.
   logic                   level_req;         // Live low-level request.
   logic                   ext_flag_raw;      // Stored edge flag.
   logic                   lock_block;        // Boot lock blocking.
   logic                   gate_open;         // Interrupts may be taken.

   assign mcu_wr = io_wr && (io_addr == `EIVS_MCU_CONTROL_ADDR);
   assign sense_control_hi = ext_irq_control_reg[1];
   assign sense_control_lo = ext_irq_control_reg[0];
   assign sense_mode = {sense_control_hi, sense_control_lo};

   // Read data shows the live control bits, reserved bits as zero.
   always_comb begin
      io_rdata = 8'h00;
      if (io_addr == `EIVS_MCU_CONTROL_ADDR) begin
         io_rdata[`EIVS_BIT_CHANGE_EN] = change_enable;
         io_rdata[`EIVS_BIT_TABLE_SEL] = vector_table_select;
         io_rdata[`EIVS_BIT_PULLUP_DIS] = pullup_disable;
         io_rdata[`EIVS_BIT_DEBUG_DIS] = debug_port_disable;
      end
   end

   // Plain bits of the control register take every write.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pullup_disable <= 1'b0;
         debug_port_disable <= 1'b0;
      end else if (mcu_wr) begin
         pullup_disable <= io_wdata[`EIVS_BIT_PULLUP_DIS];
         debug_port_disable <= io_wdata[`EIVS_BIT_DEBUG_DIS];
      end
   end

   // Protected select sequence. The select only changes on a write
   // with enable clear while armed; any other write leaves it alone,
   // which guards the vector table against stray stores.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         seq_state <= eivs_pkg::EIVS_IDLE;
         change_enable <= 1'b0;
         vector_table_select <= 1'b0;
         window_cnt <= 3'h0;
      end else begin
         case (seq_state)
            eivs_pkg::EIVS_IDLE: begin
               if (mcu_wr && io_wdata[`EIVS_BIT_CHANGE_EN]) begin
                  seq_state <= eivs_pkg::EIVS_ARMED;
                  change_enable <= 1'b1;
                  window_cnt <= 3'h1;
               end
            end
            eivs_pkg::EIVS_ARMED: begin
               if (mcu_wr && !io_wdata[`EIVS_BIT_CHANGE_EN]) begin
                  // Select write ends the window at once.
                  vector_table_select <=
                     io_wdata[`EIVS_BIT_TABLE_SEL];
                  change_enable <= 1'b0;
                  seq_state <= eivs_pkg::EIVS_TRAIL;
                  window_cnt <= 3'h0;
               end else if (window_cnt == `EIVS_CHANGE_WINDOW) begin
                  change_enable <= 1'b0;
                  seq_state <= eivs_pkg::EIVS_IDLE;
                  window_cnt <= 3'h0;
               end else begin
                  window_cnt <= window_cnt + 3'h1;
               end
            end
            eivs_pkg::EIVS_TRAIL: begin
               // One more cycle covers the following instruction.
               seq_state <= eivs_pkg::EIVS_IDLE;
            end
            default: begin
               seq_state <= eivs_pkg::EIVS_IDLE;
            end
         endcase
      end
   end

   // Boot locks block interrupts from the section opposite the table.
   assign lock_block = vector_table_select
      ? (app_side_boot_lock && !exec_in_boot)
      : (boot_side_boot_lock && exec_in_boot);

   // Blocking is separate from the global enable input, never written.
   assign irq_blocked = (seq_state != eivs_pkg::EIVS_IDLE)
      || lock_block;
   assign gate_open = global_irq_enable && !irq_blocked;

   // Two-stage synchronisers; pin reads ignore output direction.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ext_sync1 <= 1'b1;
         ext_sync2 <= 1'b1;
         ext_prev <= 1'b1;
         pc_sync1 <= '0;
         pc_sync2 <= '0;
         pc_prev <= '0;
      end else begin
         ext_sync1 <= ext_irq_pin;
         ext_sync2 <= ext_sync1;
         if (io_clock_running) begin
            ext_prev <= ext_sync2;
         end
         pc_sync1 <= pin_change_inputs;
         pc_sync2 <= pc_sync1;
         pc_prev <= pc_sync2;
      end
   end

   // Edge detector on synchronised samples, per sense mode.
   always_comb begin
      ext_event = 1'b0;
      if (io_clock_running) begin
         case (sense_mode)
            `EIVS_SENSE_ANY: ext_event = ext_sync2 ^ ext_prev;
            `EIVS_SENSE_FALL: ext_event = ext_prev && !ext_sync2;
            `EIVS_SENSE_RISE: ext_event = !ext_prev && ext_sync2;
            default: ext_event = 1'b0;
         endcase
      end
   end

   // Low level is a live request with no stored flag. It reads the second
   // synchroniser stage, so a metastable pin never reaches the take logic.
   // That stage runs on the system clock, not the gated I/O clock, so the
   // request still stands while the I/O clock is halted.
   assign level_req = (sense_mode == `EIVS_SENSE_LOW) && !ext_sync2
      && ext_irq_enable;

   // Pin-change groups: any enabled pin that toggles raises a request.
   assign pc_mask = {pin_change_mask_grp3, pin_change_mask_grp2,
                     pin_change_mask_grp1, pin_change_mask_grp0};
   genvar g;
   generate
      for (g = 0; g < GROUPS; g++) begin : grp
         localparam int LO = 8 * g;
         localparam int HI = (8 * g + 7 < PINS) ? 8 * g + 7 : PINS - 1;
         assign grp_event[g] = |((pc_sync2[HI:LO] ^ pc_prev[HI:LO])
            & pc_mask[HI:LO]);
         // Set wins over a same-cycle clear.
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               pin_change_flag[g] <= 1'b0;
            end else if (grp_event[g]) begin
               pin_change_flag[g] <= 1'b1;
            end else if (flag_clear_grp[g] || handler_entry_grp[g]) begin
               pin_change_flag[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // External flag; set wins over clear.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ext_flag_raw <= 1'b0;
      end else if (sense_mode == `EIVS_SENSE_LOW) begin
         ext_flag_raw <= 1'b0;
      end else if (ext_event) begin
         ext_flag_raw <= 1'b1;
      end else if (flag_clear_ext || handler_entry_ext) begin
         ext_flag_raw <= 1'b0;
      end
   end
   assign ext_irq_flag = ext_flag_raw;

   // Take requires both enables; a level that faded before start-up
   // ends still woke the part but no longer requests here.
   assign ext_irq_take = gate_open && ext_irq_enable && startup_done
      && (ext_flag_raw || level_req);
   assign pin_change_take = {GROUPS{gate_open}} & pin_change_enable
      & pin_change_flag;
   // Wake uses only the free-running synchronisers, so it works with the
   // I/O clock stopped.
   assign wake_request = level_req
      || |(pin_change_enable & pin_change_flag);

   // Assertions.
   sequence arm_s;
      mcu_wr && io_wdata[`EIVS_BIT_CHANGE_EN]
         && seq_state == eivs_pkg::EIVS_IDLE;
   endsequence

   arm_blocks_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      arm_s |=> irq_blocked && change_enable)
      else $error("Arming did not block interrupts.");
   timeout_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      arm_s ##1 (!mcu_wr) [*4] |=> !change_enable)
      else $error("Enable bit did not expire after four cycles.");
   stray_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      mcu_wr && seq_state == eivs_pkg::EIVS_IDLE
      |=> $stable(vector_table_select))
      else $error("Select changed outside the window.");
   gie_untouched_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      irq_blocked |-> !ext_irq_take && pin_change_take == '0)
      else $error("Interrupt taken while blocked.");
   level_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sense_mode == `EIVS_SENSE_LOW |=> !ext_irq_flag)
      else $error("Flag set in low-level mode.");
   fall_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sense_mode == `EIVS_SENSE_FALL && io_clock_running
      && $fell(ext_sync2) && ext_prev |=> ext_irq_flag
      || sense_mode == `EIVS_SENSE_LOW)
      else $error("Falling edge missed.");
   take_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ext_irq_take |-> global_irq_enable && ext_irq_enable)
      else $error("External take without enables.");
   group_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      grp_event[0] |=> pin_change_flag[0])
      else $error("Group 0 toggle lost.");
   lock_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      vector_table_select && app_side_boot_lock && !exec_in_boot
      |-> irq_blocked)
      else $error("Boot lock did not block.");

   // A select write while armed ends the window at once, then keeps the
   // block for one trailing cycle before going idle.
   sequence select_wr_s;
      mcu_wr && !io_wdata[`EIVS_BIT_CHANGE_EN]
         && seq_state == eivs_pkg::EIVS_ARMED;
   endsequence
   sequence trail_s;
      seq_state == eivs_pkg::EIVS_TRAIL && !change_enable && irq_blocked
         ##1 seq_state == eivs_pkg::EIVS_IDLE;
   endsequence
   select_trail_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      select_wr_s |=> trail_s)
      else $error("Select write did not end the window.");

   // A held low level with every enable set must be taken.
   level_take_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      level_req && gate_open && startup_done |-> ext_irq_take)
      else $error("Low level not taken.");

   // No external interrupt is taken before start-up has completed.
   startup_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !startup_done |-> !ext_irq_take)
      else $error("Take before start-up completed.");

   // External pin edges are never seen while the I/O clock is halted.
   edge_clock_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !io_clock_running |-> !ext_event)
      else $error("Edge seen without the I/O clock.");

   // A toggle on masked pins only must not raise group 0.
   group_mask_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ((pc_sync2[7:0] ^ pc_prev[7:0]) & pc_mask[7:0]) == 8'h00
      |-> !grp_event[0])
      else $error("Masked pin raised group 0.");

   // A clear with no competing event empties the group flag.
   group_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (flag_clear_grp[0] || handler_entry_grp[0]) && !grp_event[0]
      |=> !pin_change_flag[0])
      else $error("Group 0 flag not cleared.");

   // A live low level always asks to wake the part.
   wake_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      level_req |-> wake_request)
      else $error("Low level did not request wake.");
endmodule

//--- verification/eivs_pin_src.sv
// Board-side model of the external interrupt and pin-change sources.
`timescale 1ns/1ps
`include "eivs_regs.svh"
module eivs_pin_src (
   input  wire logic                       clk_sys,
   output logic                            ext_irq_pin,
   output logic [`EIVS_PIN_COUNT-1:0]      pin_change_inputs
);
   // The external line idles high like a pulled-up pin; the rest start low.
   initial begin
      ext_irq_pin = 1'b1;
      pin_change_inputs = '0;
   end
   // Drive the external line, then hold it; a short hold is stretched to
   // two cycles, because a pulse of one clock or less may go unseen.
   task automatic drive_ext(input logic lvl, input int hold);
      int n;
      n = (hold < 2) ? 2 : hold;
      @(posedge clk_sys);
      ext_irq_pin <= lvl;
      repeat (n) @(posedge clk_sys);
   endtask
   // Toggle one pin-change input and keep the new level a while.
   task automatic toggle_pin(input int idx, input int hold);
      int n;
      n = (hold < 2) ? 2 : hold;
      @(posedge clk_sys);
      pin_change_inputs[idx] <= ~pin_change_inputs[idx];
      repeat (n) @(posedge clk_sys);
   endtask
endmodule

//--- verification/ext_irq_vector_select_bench.sv
// Self-checking bench for the vector select and external interrupt block.
`timescale 1ns/1ps
`include "eivs_regs.svh"
module ext_irq_vector_select_bench;
   // One ordinary sense case: mode, level before, level after, flag.
   typedef struct packed {
      logic [1:0] mode;
      logic       from;
      logic       to;
      logic       flag;
   } eivs_row_t;
   eivs_row_t   rows [7] = '{
      '{`EIVS_SENSE_ANY, 1'b1, 1'b0, 1'b1},
      '{`EIVS_SENSE_ANY, 1'b0, 1'b1, 1'b1},
      '{`EIVS_SENSE_FALL, 1'b1, 1'b0, 1'b1},
      '{`EIVS_SENSE_FALL, 1'b0, 1'b1, 1'b0},
      '{`EIVS_SENSE_RISE, 1'b0, 1'b1, 1'b1},
      '{`EIVS_SENSE_RISE, 1'b1, 1'b0, 1'b0},
      '{`EIVS_SENSE_LOW, 1'b1, 1'b0, 1'b0}};
   logic        clk_sys = 1'b0, sys_rst = 1'b1, io_wr = 1'b0;
   logic [7:0]  io_addr = 8'h00, io_wdata = 8'h00, io_rdata;
   logic        global_irq_enable = 1'b0, ext_irq_enable = 1'b0;
   logic [3:0]  pin_change_enable = 4'h0, flag_clear_grp = 4'h0;
   logic [3:0]  handler_entry_grp = 4'h0, pin_change_flag, pin_change_take;
   logic [2:0]  ext_irq_control_reg = 3'h0;
   logic [7:0]  pin_change_mask_grp0 = 8'h00, pin_change_mask_grp1 = 8'h00;
   logic [7:0]  pin_change_mask_grp2 = 8'h00, pin_change_mask_grp3 = 8'h00;
   logic        flag_clear_ext = 1'b0, handler_entry_ext = 1'b0;
   logic        io_clock_running = 1'b1, startup_done = 1'b1;
   logic        exec_in_boot = 1'b0, app_side_boot_lock = 1'b0;
   logic        boot_side_boot_lock = 1'b0, ext_irq_pin, ext_irq_take;
   logic [30:0] pin_change_inputs;
   logic        vector_table_select, irq_blocked, ext_irq_flag, wake_request;
   int          fails = 0, cmp_count = 0;

   // A 25 MHz system clock.
   always #20 clk_sys = ~clk_sys;

   eivs_core i_eivs_core (.clk_sys, .sys_rst, .io_addr, .io_wr, .io_wdata,
      .io_rdata, .global_irq_enable, .ext_irq_enable, .pin_change_enable,
      .ext_irq_control_reg, .pin_change_mask_grp0, .pin_change_mask_grp1,
      .pin_change_mask_grp2, .pin_change_mask_grp3, .flag_clear_ext,
      .flag_clear_grp, .handler_entry_ext, .handler_entry_grp, .ext_irq_pin,
      .pin_change_inputs, .io_clock_running, .startup_done, .exec_in_boot,
      .app_side_boot_lock, .boot_side_boot_lock, .vector_table_select,
      .irq_blocked, .ext_irq_flag, .pin_change_flag, .ext_irq_take,
      .pin_change_take, .wake_request);
   eivs_pin_src i_eivs_pin_src (.clk_sys, .ext_irq_pin, .pin_change_inputs);

   // Compare one flag; case inequality so an unknown never matches.
   task automatic check_bit(input logic got, input logic exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   // Compare one register byte.
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                             input string m);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   // Write the control register; the write is taken at the second edge.
   task automatic wr(input logic [7:0] data);
      @(posedge clk_sys);
      io_addr  <= `EIVS_MCU_CONTROL_ADDR;
      io_wdata <= data;
      io_wr    <= 1'b1;
      @(posedge clk_sys);
      io_wr <= 1'b0;
   endtask
   // Read back combinationally once the address has settled.
   task automatic rd_check(input logic [7:0] a, input logic [7:0] exp,
                           input string m);
      @(posedge clk_sys);
      io_addr <= a;
      @(negedge clk_sys);
      check_byte(io_rdata, exp, m);
   endtask
   // One-cycle clear pulse for the external flag and group flags.
   task automatic clear_flags(input logic ext, input logic [3:0] grp);
      @(posedge clk_sys);
      flag_clear_ext    <= ext;
      handler_entry_ext <= ext;
      flag_clear_grp    <= grp;
      handler_entry_grp <= grp;
      @(posedge clk_sys);
      flag_clear_ext    <= 1'b0;
      handler_entry_ext <= 1'b0;
      flag_clear_grp    <= 4'h0;
      handler_entry_grp <= 4'h0;
   endtask
   // Print the counts and the verdict, then stop.
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // The whole run needs some 160 cycles; a hang is cut off well after.
   initial begin
      repeat (4000) @(posedge clk_sys);
      fails++;
      print_verdict();
   end

   initial begin
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd_check(`EIVS_MCU_CONTROL_ADDR, `EIVS_MCU_CONTROL_RST, "reset");
      check_bit(vector_table_select, 1'b0, "select at reset");
      $display("test reset done");
      // Ordinary sense cases: settle, clear the flag, then move the pin.
      foreach (rows[i]) begin
         ext_irq_control_reg <= {1'b0, rows[i].mode};
         i_eivs_pin_src.drive_ext(rows[i].from, 4);
         clear_flags(1'b1, 4'h0);
         i_eivs_pin_src.drive_ext(rows[i].to, 5);
         @(negedge clk_sys);
         check_bit(ext_irq_flag, rows[i].flag, "sense flag");
      end
      $display("test sense rows done");
      // Arm, then move the table two cycles later.
      wr(8'h01);
      @(negedge clk_sys);
      check_bit(irq_blocked, 1'b1, "blocked after arm");
      wr(8'h02);
      rd_check(`EIVS_MCU_CONTROL_ADDR, 8'h02, "select moved");
      check_bit(vector_table_select, 1'b1, "select output");
      // Arm and let the window run out; a late write must be refused.
      wr(8'h01);
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      check_byte(io_rdata, 8'h02, "enable timed out");
      check_bit(irq_blocked, 1'b0, "block released");
      wr(8'h00);
      rd_check(`EIVS_MCU_CONTROL_ADDR, 8'h02, "late write");
      wr(8'h90);
      rd_check(`EIVS_MCU_CONTROL_ADDR, 8'h92, "unarmed write");
      rd_check(8'h36, 8'h00, "unmapped read");
      wr(8'h01);
      wr(8'h00);
      rd_check(`EIVS_MCU_CONTROL_ADDR, 8'h00, "select cleared");
      $display("test vector select done");
      // Boot-side lock with application vectors blocks boot-side code.
      @(posedge clk_sys);
      boot_side_boot_lock <= 1'b1;
      exec_in_boot        <= 1'b1;
      @(negedge clk_sys);
      check_bit(irq_blocked, 1'b1, "boot lock block");
      @(posedge clk_sys);
      exec_in_boot <= 1'b0;
      @(negedge clk_sys);
      check_bit(irq_blocked, 1'b0, "application unblocked");
      boot_side_boot_lock <= 1'b0;
      // Low level keeps requesting, gated by both enables.
      ext_irq_control_reg <= {1'b0, `EIVS_SENSE_LOW};
      global_irq_enable   <= 1'b1;
      ext_irq_enable      <= 1'b1;
      i_eivs_pin_src.drive_ext(1'b0, 3);
      @(negedge clk_sys);
      check_bit(ext_irq_take, 1'b1, "low level take");
      @(posedge clk_sys);
      global_irq_enable <= 1'b0;
      io_clock_running  <= 1'b0;
      @(negedge clk_sys);
      check_bit(ext_irq_take, 1'b0, "global enable off");
      check_bit(wake_request, 1'b1, "low level wake");
      startup_done      <= 1'b0;
      global_irq_enable <= 1'b1;
      @(negedge clk_sys);
      check_bit(ext_irq_take, 1'b0, "start-up pending");
      check_bit(wake_request, 1'b1, "start-up wake");
      startup_done <= 1'b1;
      i_eivs_pin_src.drive_ext(1'b1, 3);
      @(negedge clk_sys);
      check_bit(ext_irq_take, 1'b0, "level ended");
      $display("test low level done");
      // Falling edge with the I/O clock halted is not recognised.
      ext_irq_control_reg <= {1'b0, `EIVS_SENSE_FALL};
      clear_flags(1'b1, 4'h0);
      i_eivs_pin_src.drive_ext(1'b0, 5);
      @(negedge clk_sys);
      check_bit(ext_irq_flag, 1'b0, "edge without clock");
      // Pin changes work with the I/O clock halted, per mask bit.
      pin_change_mask_grp0 <= 8'h08;
      pin_change_enable    <= 4'h3;
      i_eivs_pin_src.toggle_pin(3, 5);
      i_eivs_pin_src.toggle_pin(9, 5);
      @(negedge clk_sys);
      check_bit(pin_change_flag[0], 1'b1, "group 0 flag");
      check_bit(pin_change_flag[1], 1'b0, "masked pin");
      pin_change_mask_grp1 <= 8'h02;
      i_eivs_pin_src.toggle_pin(9, 5);
      @(negedge clk_sys);
      check_bit(pin_change_flag[1], 1'b1, "group 1 flag");
      check_bit(pin_change_take[1], 1'b1, "group 1 take");
      clear_flags(1'b0, 4'h3);
      @(negedge clk_sys);
      check_byte({4'h0, pin_change_flag}, 8'h00, "entry clears");
      $display("test pin change done");
      print_verdict();
   end
endmodule
